// *** rtl/slicmc_params.svh ***
`ifndef SLICMC_PARAMS_SVH
`define SLICMC_PARAMS_SVH

// ****************************************
// timing
// ****************************************
`define SLICMC_CLK_PERIOD_NS      10
`define SLICMC_FREEZE_TIME_NS     10000000
`define SLICMC_FREEZE_CYCLES      (`SLICMC_FREEZE_TIME_NS / `SLICMC_CLK_PERIOD_NS)
`define SLICMC_PERSIST_UNIT_NS    1000000
`define SLICMC_PERSIST_CYCLES     (`SLICMC_PERSIST_UNIT_NS / `SLICMC_CLK_PERIOD_NS)
`define SLICMC_OVERSAMPLE_HZ      256000
`define SLICMC_OVERSAMPLE_CYCLES  (1000000000 / (`SLICMC_OVERSAMPLE_HZ * `SLICMC_CLK_PERIOD_NS))
`define SLICMC_GK_LP_MAX          4'h0F

// ****************************************
// command and configuration fields
// ****************************************
`define SLICMC_CI_MODE_HI         7
`define SLICMC_CI_MODE_LO         5
`define SLICMC_CI_RING_SEL        6
`define SLICMC_CI_METER           5
`define SLICMC_CFG_ENABLE         7
`define SLICMC_CFG_WIRE_HI        3
`define SLICMC_CFG_WIRE_LO        2

// ****************************************
// line status bits (upstream and status; frozen bit in the status word only)
// ****************************************
`define SLICMC_ST_OFFHOOK         7
`define SLICMC_ST_GNDKEY          6
`define SLICMC_ST_BATLOW          5
`define SLICMC_ST_THERMAL         4
`define SLICMC_ST_FROZEN          0

// ****************************************
// synchronised pin indices
// ****************************************
`define SLICMC_PIN_HOOK           0
`define SLICMC_PIN_WIRE1          1
`define SLICMC_PIN_WIRE2          2
`define SLICMC_PIN_LONG           3
`define SLICMC_PIN_BAT            4
`define SLICMC_PIN_THERM          5
`define SLICMC_NPINS              6

// ****************************************
// reset values
// ****************************************
`define SLICMC_RST_BYTE           8'h00
`define SLICMC_RST_SINK           1'b0

`endif

// *** rtl/slicmc_persist.sv ***
`timescale 1ns/1ps
`include "slicmc_params.svh"

module slicmc_persist (
	// clock and reset
	input wire logic      clk,
	input wire logic      rst,
	// filter port
	slicmc_persist_if.filt pif
);

	typedef struct packed {
		logic       out;
		logic [7:0] cnt;
	} slicmc_pst_s;

	slicmc_pst_s st_q;
	slicmc_pst_s st_d;

	// output follows input once it held for length plus one ticks
	always_comb begin
		st_d = st_q;
		if (pif.sample == st_q.out) begin
			st_d.cnt = pif.length;
		end else if (pif.tick) begin
			if (st_q.cnt == 8'h00) begin
				st_d.out = pif.sample;
				st_d.cnt = pif.length;
			end else begin
				st_d.cnt = st_q.cnt - 8'h01;
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pif.filtered = st_q.out;

endmodule // slicmc_persist

// *** rtl/slicmc_persist_if.sv ***
`timescale 1ns/1ps

// persistence filter hookup
interface slicmc_persist_if;
	logic       sample;
	logic       tick;
	logic [7:0] length;
	logic       filtered;

	modport filt (input sample, input tick, input length, output filtered);
	modport user (output sample, output tick, output length, input filtered);
endinterface

// *** rtl/slicmc_pkg.sv ***
package slicmc_pkg;

	// ****************************************
	// ternary control line levels
	// ****************************************
	typedef enum logic [1:0] {
		TERN_HIGH = 2'b00,
		TERN_MID  = 2'b01,
		TERN_LOW  = 2'b10
	} slicmc_tern_e;

	// ****************************************
	// operating modes, one-hot
	// ****************************************
	typedef enum logic [7:0] {
		MODE_EXT_IND   = 8'b0000_0001,
		MODE_LOOP_OPEN = 8'b0000_0010,
		MODE_STANDBY   = 8'b0000_0100,
		MODE_GND_START = 8'b0000_1000,
		MODE_ACTIVE    = 8'b0001_0000,
		MODE_ACT_METER = 8'b0010_0000,
		MODE_RING      = 8'b0100_0000,
		MODE_RING_RED  = 8'b1000_0000
	} slicmc_mode_e;

endpackage

// *** rtl/slicmc_top.sv ***
// What this block does
// R1: strobe receive-path oversampling at 256 kHz for the summing stage.
// R2: ground key from longitudinal current comparator, low-pass, then persistence filter.
// R3: report battery image comparison as one upstream status bit.
// R4: drive both ternary control lines from received mode commands.
// R5: sensed extra current on line a flags driver thermal overload.
// R6: zero sink current means external indication, both low means loop open.
// R7: no sink current forces power denial; sinking turns the driver on.
// R8: in power denial detect off-hook from the line wire sense inputs.
// R9: pass ring setup and metering level; stop ringing on ring trip.
// R10: report line state both upstream and in the line status word.
// R11: freeze line indication 10 ms plus persistence on every mode switch.
// R12: in power down only off-hook detection stays powered, plus ground key in standby and ground start.
// R13: decode power-down submodes from command bits and config bits 7, 3, 2.
// R14: external indication removes the power-enable sink current.
// R15: controller picks loop open only with resistor-integrating drivers.
// R16: standby uses standby feed word; off-hook and ground key run.
// R17: ground start is standby feeding with tip wire high impedance.
// R18: command 010 selects active, 011 active with metering.
// R19: active with config bits 3,2 unequal puts one wire high impedance.
// R20: active uses active feed word; off-hook and ground key run.
// R21: command bit 5 set in active superimposes metering onto voice.
// R22: command 11 selects ring, 10 reduced ring; config 3,2 equal.
// R23: reset gives external indication and power denial.
`timescale 1ns/1ps
`include "slicmc_params.svh"

module slicmc_top #(
	parameter int FREEZE_CYCLES  = `SLICMC_FREEZE_CYCLES,
	parameter int PERSIST_CYCLES = `SLICMC_PERSIST_CYCLES
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// downstream command from the backplane
	input  wire logic [7:0]          ci_down,
	input  wire logic                ci_valid,
	// configuration words
	input  wire logic [7:0]          mode_config_reg,
	input  wire logic [7:0]          ground_key_persistence_reg,
	input  wire logic [7:0]          active_feed_reg,
	input  wire logic [7:0]          standby_feed_reg,
	input  wire logic [7:0]          ring_setup_reg,
	input  wire logic [7:0]          metering_level_reg,
	input  wire logic                polarity_reverse,
	input  wire logic                boost_enable,
	// comparator pins from the analog front end
	input  wire logic                hook_comp_in,
	input  wire logic                line_wire_sense_one,
	input  wire logic                line_wire_sense_two,
	input  wire logic                longitudinal_current_input,
	input  wire logic                battery_compare_in,
	input  wire logic                thermal_sense_in,
	// driver control
	output slicmc_pkg::slicmc_tern_e hv_control_line_a,
	output slicmc_pkg::slicmc_tern_e hv_control_line_b,
	output logic                     hv_power_enable_sink,
	// analog steering
	output logic                     analog_power_on,
	output logic                     rx_oversample_tick,
	output logic                     metering_signal,
	output logic                     ring_enable,
	output logic                     ring_reduced,
	output logic                     tip_hiz,
	output logic                     ring_hiz,
	output logic [7:0]               feed_word,
	output logic [7:0]               ring_word,
	output logic [7:0]               meter_word,
	// status
	output slicmc_pkg::slicmc_mode_e current_mode,
	output logic [7:0]               ci_up,
	output logic [7:0]               line_status_reg,
	output logic                     status_change
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		slicmc_pkg::slicmc_mode_e mode;
		slicmc_pkg::slicmc_tern_e la;
		slicmc_pkg::slicmc_tern_e lb;
		logic                     sink;
		logic [7:0]               ci;
		logic [5:0]               s1;
		logic [5:0]               s2;
		logic [5:0]               s3;
		logic [5:0]               pin;
		logic [3:0]               gk_lp;
		logic                     gk_raw;
		logic                     hook_raw;
		logic                     freezing;
		logic [19:0]              frz_cnt;
		logic [7:0]               frz_pers;
		logic [16:0]              tick_cnt;
		logic                     tick;
		logic [8:0]               os_cnt;
		logic                     os_tick;
		logic [7:0]               status;
		logic                     chg;
		logic [7:0]               feed;
		logic [7:0]               ring_w;
		logic [7:0]               meter_w;
		logic                     meter_en;
		logic                     ring_en;
		logic                     ring_red;
		logic                     tip_z;
		logic                     ring_z;
		logic                     power_on;
	} slicmc_st_s;

	slicmc_st_s st_q;
	slicmc_st_s st_d;

	localparam logic [8:0]  OS_LAST   = 9'(`SLICMC_OVERSAMPLE_CYCLES - 1);
	localparam logic [19:0] FRZ_LAST  = 20'(FREEZE_CYCLES - 1);
	localparam logic [16:0] TICK_LAST = 17'(PERSIST_CYCLES - 1);

	slicmc_persist_if gk_if ();
	slicmc_persist_if hook_if ();

	logic       gk_f;
	logic       hook_f;
	logic       chosen_ok;
	logic [5:0] pin_sync;
	logic [7:0] new_status;
	logic       detect_on;
	logic       power_down;
	slicmc_pkg::slicmc_mode_e chosen;

	// ****************************************
	// persistence filters
	// ****************************************
	assign gk_if.sample   = st_q.gk_raw;
	assign gk_if.tick     = st_q.tick;
	assign gk_if.length   = ground_key_persistence_reg;
	assign hook_if.sample = st_q.hook_raw;
	assign hook_if.tick   = st_q.tick;
	assign hook_if.length = ground_key_persistence_reg;
	assign gk_f           = gk_if.filtered;
	assign hook_f         = hook_if.filtered;

	slicmc_persist u_gk_persist (
		.clk (clk),
		.rst (rst),
		.pif (gk_if.filt)
	);

	slicmc_persist u_hook_persist (
		.clk (clk),
		.rst (rst),
		.pif (hook_if.filt)
	);

	// ****************************************
	// mode decode from latched command and config
	// ****************************************
	always_comb begin
		chosen    = st_q.mode;
		chosen_ok = 1'b1;
		case (st_q.ci[`SLICMC_CI_MODE_HI:`SLICMC_CI_MODE_LO])
			3'b000: begin // see R13
				if (!mode_config_reg[`SLICMC_CFG_ENABLE]) begin
					chosen = slicmc_pkg::MODE_EXT_IND;
				end else if (mode_config_reg[3:2] == 2'b00) begin
					chosen = slicmc_pkg::MODE_STANDBY;
				end else if (mode_config_reg[3:2] == 2'b11) begin
					chosen = slicmc_pkg::MODE_GND_START;
				end else begin
					chosen_ok = 1'b0;
				end
			end
			3'b001: begin
				chosen = slicmc_pkg::MODE_LOOP_OPEN; // see R13 see R15
			end
			3'b010: begin
				chosen = slicmc_pkg::MODE_ACTIVE; // see R18
			end
			3'b011: begin
				chosen = slicmc_pkg::MODE_ACT_METER; // see R18
			end
			default: begin // see R22
				if (mode_config_reg[`SLICMC_CFG_WIRE_HI] != mode_config_reg[`SLICMC_CFG_WIRE_LO]) begin
					chosen_ok = 1'b0;
				end else if (st_q.ci[`SLICMC_CI_RING_SEL]) begin
					chosen = slicmc_pkg::MODE_RING;
				end else begin
					chosen = slicmc_pkg::MODE_RING_RED;
				end
			end
		endcase
	end

	// ****************************************
	// detection helpers
	// ****************************************
	assign pin_sync   = {thermal_sense_in, battery_compare_in, longitudinal_current_input,
	                     line_wire_sense_two, line_wire_sense_one, hook_comp_in};
	assign power_down = st_q.mode inside {slicmc_pkg::MODE_EXT_IND, slicmc_pkg::MODE_LOOP_OPEN,
	                                      slicmc_pkg::MODE_STANDBY, slicmc_pkg::MODE_GND_START};
	assign detect_on  = st_q.mode inside {slicmc_pkg::MODE_STANDBY, slicmc_pkg::MODE_GND_START,
	                                      slicmc_pkg::MODE_ACTIVE, slicmc_pkg::MODE_ACT_METER};

	// live line status word
	always_comb begin
		new_status                     = '0;
		new_status[`SLICMC_ST_OFFHOOK] = hook_f;
		new_status[`SLICMC_ST_GNDKEY]  = gk_f;
		new_status[`SLICMC_ST_BATLOW]  = st_q.pin[`SLICMC_PIN_BAT]; // see R3
		new_status[`SLICMC_ST_THERMAL] = st_q.pin[`SLICMC_PIN_THERM]; // see R5
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;

		// command capture
		if (ci_valid) begin
			st_d.ci = ci_down;
		end

		// three-stage pin sampling, accept when last two agree
		st_d.s1  = pin_sync;
		st_d.s2  = st_q.s1;
		st_d.s3  = st_q.s2;
		st_d.pin = (st_q.s2 & st_q.s3) | (st_q.pin & (st_q.s2 ^ st_q.s3));

		// receive oversampling strobe
		st_d.os_tick = 1'b0;
		if (st_q.os_cnt == OS_LAST) begin // see R1
			st_d.os_cnt  = '0;
			st_d.os_tick = 1'b1;
		end else begin
			st_d.os_cnt = st_q.os_cnt + 9'h001;
		end

		// persistence time base
		st_d.tick = 1'b0;
		if (st_q.tick_cnt == TICK_LAST) begin
			st_d.tick_cnt = '0;
			st_d.tick     = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 17'h0_0001;
		end

		// ground key low-pass integrator with hysteresis
		if (st_q.pin[`SLICMC_PIN_LONG] && detect_on) begin // see R2
			if (st_q.gk_lp != `SLICMC_GK_LP_MAX) begin
				st_d.gk_lp = st_q.gk_lp + 4'h1;
			end
		end else if (st_q.gk_lp != 4'h0) begin
			st_d.gk_lp = st_q.gk_lp - 4'h1;
		end
		if (st_q.gk_lp == `SLICMC_GK_LP_MAX) begin
			st_d.gk_raw = 1'b1; // see R2
		end else if (st_q.gk_lp == 4'h0) begin
			st_d.gk_raw = 1'b0;
		end

		// off-hook source: wire sense in power denial
		if (!st_q.sink) begin // see R8
			st_d.hook_raw = st_q.pin[`SLICMC_PIN_WIRE1] | st_q.pin[`SLICMC_PIN_WIRE2];
		end else begin
			st_d.hook_raw = st_q.pin[`SLICMC_PIN_HOOK];
		end

		// mode switch starts the indication freeze
		if (chosen_ok && (chosen != st_q.mode)) begin
			st_d.mode     = chosen;
			st_d.freezing = 1'b1; // see R11
			st_d.frz_cnt  = FRZ_LAST;
			st_d.frz_pers = ground_key_persistence_reg;
		end else if (st_q.freezing) begin
			if (st_q.frz_cnt != '0) begin // see R11
				st_d.frz_cnt = st_q.frz_cnt - 20'h0_0001;
			end else if (st_q.tick) begin
				if (st_q.frz_pers == 8'h00) begin
					st_d.freezing = 1'b0;
				end else begin
					st_d.frz_pers = st_q.frz_pers - 8'h01;
				end
			end
		end

		// line status, held while frozen
		st_d.chg = 1'b0;
		if (!st_q.freezing) begin // see R10
			if (new_status != st_q.status) begin
				st_d.chg = 1'b1;
			end
			st_d.status = new_status;
		end

		// driver control lines and steering per mode
		st_d.la       = slicmc_pkg::TERN_HIGH;
		st_d.lb       = slicmc_pkg::TERN_HIGH;
		st_d.sink     = 1'b1; // see R7
		st_d.feed     = standby_feed_reg;
		st_d.tip_z    = 1'b0;
		st_d.ring_z   = 1'b0;
		st_d.meter_en = 1'b0;
		st_d.ring_en  = 1'b0;
		st_d.ring_red = 1'b0;
		st_d.power_on = !power_down; // see R12
		st_d.ring_w   = ring_setup_reg; // see R9
		st_d.meter_w  = metering_level_reg; // see R9
		case (st_q.mode)
			slicmc_pkg::MODE_EXT_IND: begin
				st_d.sink = 1'b0; // see R14 see R6
			end
			slicmc_pkg::MODE_LOOP_OPEN: begin
				st_d.sink = 1'b0; // see R6
				st_d.la   = slicmc_pkg::TERN_LOW;
				st_d.lb   = slicmc_pkg::TERN_LOW;
			end
			slicmc_pkg::MODE_STANDBY: begin
				st_d.feed = standby_feed_reg; // see R16 see R4
			end
			slicmc_pkg::MODE_GND_START: begin
				st_d.la    = slicmc_pkg::TERN_MID; // see R17 see R4
				st_d.tip_z = 1'b1;
			end
			slicmc_pkg::MODE_ACTIVE, slicmc_pkg::MODE_ACT_METER: begin
				st_d.feed     = active_feed_reg; // see R20
				st_d.meter_en = (st_q.mode == slicmc_pkg::MODE_ACT_METER); // see R21
				if (mode_config_reg[`SLICMC_CFG_WIRE_HI] != mode_config_reg[`SLICMC_CFG_WIRE_LO]) begin
					st_d.tip_z  = mode_config_reg[`SLICMC_CFG_WIRE_HI]; // see R19
					st_d.ring_z = !mode_config_reg[`SLICMC_CFG_WIRE_HI];
					st_d.la     = mode_config_reg[`SLICMC_CFG_WIRE_HI] ?
					              slicmc_pkg::TERN_MID : slicmc_pkg::TERN_LOW;
				end else begin
					st_d.la = boost_enable ? slicmc_pkg::TERN_MID : slicmc_pkg::TERN_HIGH; // see R4
					st_d.lb = polarity_reverse ? slicmc_pkg::TERN_LOW : slicmc_pkg::TERN_MID;
				end
			end
			slicmc_pkg::MODE_RING, slicmc_pkg::MODE_RING_RED: begin
				st_d.la       = slicmc_pkg::TERN_LOW; // see R4
				st_d.lb       = polarity_reverse ? slicmc_pkg::TERN_LOW : slicmc_pkg::TERN_MID;
				st_d.ring_en  = !hook_f; // see R9
				st_d.ring_red = (st_q.mode == slicmc_pkg::MODE_RING_RED);
			end
			default: begin
				st_d.sink = 1'b0;
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q      <= '0;
			st_q.mode <= slicmc_pkg::MODE_EXT_IND; // see R23
			st_q.la   <= slicmc_pkg::TERN_HIGH;
			st_q.lb   <= slicmc_pkg::TERN_HIGH;
			st_q.sink <= `SLICMC_RST_SINK; // see R23
			st_q.ci   <= `SLICMC_RST_BYTE;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hv_control_line_a    = st_q.la;
	assign hv_control_line_b    = st_q.lb;
	assign hv_power_enable_sink = st_q.sink;
	assign analog_power_on      = st_q.power_on;
	assign rx_oversample_tick   = st_q.os_tick;
	assign metering_signal      = st_q.meter_en;
	assign ring_enable          = st_q.ring_en;
	assign ring_reduced         = st_q.ring_red;
	assign tip_hiz              = st_q.tip_z;
	assign ring_hiz             = st_q.ring_z;
	assign feed_word            = st_q.feed;
	assign ring_word            = st_q.ring_w;
	assign meter_word           = st_q.meter_w;
	assign current_mode         = st_q.mode;
	assign ci_up                = st_q.status;
	assign line_status_reg      = {st_q.status[7:1], st_q.freezing};
	assign status_change        = st_q.chg;

endmodule // slicmc_top

// *** testbench/slicmc_hv_model.sv ***
`timescale 1ns/1ps

// ****************************************
// driver and line model
// ****************************************
module slicmc_hv_model (
	// driver power from the codec
	input wire logic power_sink,
	// line conditions set by the bench
	input wire logic offhook,
	input wire logic gnd_fault,
	input wire logic overheat,
	input wire logic low_bat,
	// comparator pins toward the codec
	output logic     hook_comp,
	output logic     sense_one,
	output logic     sense_two,
	output logic     long_cur,
	output logic     bat_cmp,
	output logic     therm
);
	// loop sensing needs a powered driver; the resistive network always sees the wires
	assign hook_comp = power_sink & offhook;
	assign sense_one = offhook;
	assign sense_two = offhook;
	assign long_cur  = power_sink & gnd_fault;
	assign bat_cmp   = low_bat;
	assign therm     = power_sink & overheat; // extra current only when powered
endmodule // slicmc_hv_model

// *** testbench/slicmc_properties.sv ***
`timescale 1ns/1ps

// ****************************************
// port checker for the mode controller
// ****************************************
module slicmc_properties (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rst,
	// configuration words
	input wire logic [7:0]               active_feed_reg,
	input wire logic [7:0]               standby_feed_reg,
	// driver control and steering
	input wire slicmc_pkg::slicmc_tern_e hv_control_line_a,
	input wire slicmc_pkg::slicmc_tern_e hv_control_line_b,
	input wire logic                     hv_power_enable_sink,
	input wire logic                     analog_power_on,
	input wire logic                     rx_oversample_tick,
	input wire logic                     metering_signal,
	input wire logic                     tip_hiz,
	input wire logic [7:0]               feed_word,
	input wire slicmc_pkg::slicmc_mode_e current_mode
);
	int unsigned gap_q;
	logic        seen_q;

	// cycles since the last oversample strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_q  <= 0;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= rx_oversample_tick ? 0 : gap_q + 1;
			seen_q <= seen_q | rx_oversample_tick;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_reset_drive: assert property (disable iff (1'b0)
		rst |-> current_mode == slicmc_pkg::MODE_EXT_IND && !hv_power_enable_sink
		&& hv_control_line_a == slicmc_pkg::TERN_HIGH)
		else $error("reset state not held");
	chk_ext_denial: assert property (
		current_mode == slicmc_pkg::MODE_EXT_IND |=> !hv_power_enable_sink
		&& hv_control_line_b == slicmc_pkg::TERN_HIGH)
		else $error("external indication drives sink");
	chk_loop_open: assert property (
		current_mode == slicmc_pkg::MODE_LOOP_OPEN |=> !hv_power_enable_sink
		&& hv_control_line_a == slicmc_pkg::TERN_LOW
		&& hv_control_line_b == slicmc_pkg::TERN_LOW)
		else $error("loop open lines wrong");
	chk_gnd_start: assert property (
		current_mode == slicmc_pkg::MODE_GND_START |=> tip_hiz
		&& hv_control_line_a == slicmc_pkg::TERN_MID
		&& hv_control_line_b == slicmc_pkg::TERN_HIGH)
		else $error("ground start drive wrong");
	chk_active_power: assert property (
		current_mode inside {slicmc_pkg::MODE_ACTIVE, slicmc_pkg::MODE_ACT_METER}
		|=> hv_power_enable_sink && analog_power_on)
		else $error("active mode not powered");
	chk_meter_on: assert property (
		current_mode inside {slicmc_pkg::MODE_ACTIVE, slicmc_pkg::MODE_ACT_METER}
		|=> metering_signal == $past(current_mode == slicmc_pkg::MODE_ACT_METER))
		else $error("metering follows wrong mode");
	chk_feed_active: assert property (
		current_mode inside {slicmc_pkg::MODE_ACTIVE, slicmc_pkg::MODE_ACT_METER}
		|=> feed_word == $past(active_feed_reg))
		else $error("active feed word wrong");
	chk_feed_standby: assert property (
		current_mode inside {slicmc_pkg::MODE_STANDBY, slicmc_pkg::MODE_GND_START}
		|=> feed_word == $past(standby_feed_reg))
		else $error("standby feed word wrong");
	chk_power_down: assert property (
		current_mode inside {slicmc_pkg::MODE_EXT_IND, slicmc_pkg::MODE_LOOP_OPEN,
		slicmc_pkg::MODE_STANDBY, slicmc_pkg::MODE_GND_START} |=> !analog_power_on)
		else $error("power down keeps analog on");
	chk_tick_period: assert property (
		rx_oversample_tick && seen_q |-> gap_q == 389)
		else $error("oversample period wrong");
endmodule // slicmc_properties

// *** testbench/slicmc_top_tb.sv ***
`timescale 1ns/1ps

// ****************************************
// bench for the mode controller
// ****************************************
module slicmc_top_tb;
	typedef struct packed {
		logic [7:0] ci, cfg, mode;
		logic [1:0] a, b;
		logic       sink;
	} slicmc_row_s;
	localparam logic [1:0] TH = slicmc_pkg::TERN_HIGH;
	localparam logic [1:0] TM = slicmc_pkg::TERN_MID;
	localparam logic [1:0] TL = slicmc_pkg::TERN_LOW;

	logic clk, rst, ci_valid, polarity_reverse, boost_enable;
	logic offhook, gnd_fault, overheat, low_bat;
	logic hook_comp_in, line_wire_sense_one, line_wire_sense_two;
	logic longitudinal_current_input, battery_compare_in, thermal_sense_in;
	logic [7:0] ci_down, mode_config_reg, ground_key_persistence_reg;
	logic [7:0] active_feed_reg, standby_feed_reg, ring_setup_reg, metering_level_reg;
	slicmc_pkg::slicmc_tern_e hv_control_line_a, hv_control_line_b;
	slicmc_pkg::slicmc_mode_e current_mode;
	logic hv_power_enable_sink, ring_enable, ring_reduced, ring_hiz;
	logic [7:0] ring_word, meter_word, ci_up, line_status_reg;
	int bad_count, comparisons, cycles;
	slicmc_row_s rows [10];

	slicmc_top #(.FREEZE_CYCLES(50), .PERSIST_CYCLES(8)) dut (.clk, .rst, .ci_down, .ci_valid,
		.mode_config_reg, .ground_key_persistence_reg, .active_feed_reg, .standby_feed_reg,
		.ring_setup_reg, .metering_level_reg, .polarity_reverse, .boost_enable,
		.hook_comp_in, .line_wire_sense_one, .line_wire_sense_two,
		.longitudinal_current_input, .battery_compare_in, .thermal_sense_in,
		.hv_control_line_a, .hv_control_line_b, .hv_power_enable_sink,
		.analog_power_on(), .rx_oversample_tick(), .metering_signal(), .ring_enable,
		.ring_reduced, .tip_hiz(), .ring_hiz, .feed_word(), .ring_word, .meter_word,
		.current_mode, .ci_up, .line_status_reg, .status_change());

	slicmc_hv_model hv (.power_sink(hv_power_enable_sink), .offhook, .gnd_fault, .overheat,
		.low_bat, .hook_comp(hook_comp_in), .sense_one(line_wire_sense_one),
		.sense_two(line_wire_sense_two), .long_cur(longitudinal_current_input),
		.bat_cmp(battery_compare_in), .therm(thermal_sense_in));

	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apply(input logic [7:0] ci, input logic [7:0] c);
		ci_down = ci;
		mode_config_reg = c;
		ci_valid = 1'b1;
		@(negedge clk);
		ci_valid = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// main sequence, inputs change on the falling edge
	initial begin
		clk = 1'b0; rst = 1'b1; ci_valid = 1'b0; ci_down = 8'h00; mode_config_reg = 8'h00;
		polarity_reverse = 1'b0; boost_enable = 1'b0; ground_key_persistence_reg = 8'h02;
		active_feed_reg = 8'h5A; standby_feed_reg = 8'hA5; ring_setup_reg = 8'h3C;
		metering_level_reg = 8'hC3; offhook = 0; gnd_fault = 0; overheat = 0; low_bat = 0;
		bad_count = 0; comparisons = 0; cycles = 0;
		rows = '{'{8'h00, 8'h00, slicmc_pkg::MODE_EXT_IND, TH, TH, 1'b0},
			'{8'h20, 8'h00, slicmc_pkg::MODE_LOOP_OPEN, TL, TL, 1'b0}, // model integrates resistors
			'{8'h00, 8'h80, slicmc_pkg::MODE_STANDBY, TH, TH, 1'b1},
			'{8'h00, 8'h8C, slicmc_pkg::MODE_GND_START, TM, TH, 1'b1},
			'{8'h40, 8'h00, slicmc_pkg::MODE_ACTIVE, TH, TM, 1'b1},
			'{8'h60, 8'h0C, slicmc_pkg::MODE_ACT_METER, TH, TM, 1'b1},
			'{8'h40, 8'h08, slicmc_pkg::MODE_ACTIVE, TM, TH, 1'b1},
			'{8'h40, 8'h04, slicmc_pkg::MODE_ACTIVE, TL, TH, 1'b1},
			'{8'hC0, 8'h00, slicmc_pkg::MODE_RING, TL, TM, 1'b1},
			'{8'h80, 8'h0C, slicmc_pkg::MODE_RING_RED, TL, TM, 1'b1}};
		repeat (16) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		chk(current_mode, slicmc_pkg::MODE_EXT_IND);
		chk({5'h00, hv_control_line_a, hv_power_enable_sink}, {5'h00, TH, 1'b0});
		chk(line_status_reg, 8'h00);
		done("reset");
		foreach (rows[i]) begin
			apply(rows[i].ci, rows[i].cfg);
			chk(current_mode, rows[i].mode);
			chk({4'h0, hv_control_line_a, hv_control_line_b}, {4'h0, rows[i].a, rows[i].b});
			chk({7'h00, hv_power_enable_sink}, {7'h00, rows[i].sink});
		end
		chk({6'h00, ring_reduced, ring_hiz}, 8'h02);
		done("mode table");
		apply(8'h40, 8'h00);
		polarity_reverse = 1'b1;
		boost_enable = 1'b1;
		repeat (3) @(negedge clk);
		chk({4'h0, hv_control_line_a, hv_control_line_b}, {4'h0, TM, TL});
		polarity_reverse = 1'b0;
		boost_enable = 1'b0;
		done("polarity and boost");
		apply(8'h00, 8'h88);
		chk(current_mode, slicmc_pkg::MODE_ACTIVE);
		apply(8'hC0, 8'h84);
		chk(current_mode, slicmc_pkg::MODE_ACTIVE);
		done("refused");
		apply(8'h00, 8'h80);
		chk(line_status_reg & 8'h01, 8'h01);
		low_bat = 1'b1;
		repeat (20) @(negedge clk);
		chk(line_status_reg & 8'h21, 8'h01);
		repeat (37) @(negedge clk);
		chk(line_status_reg & 8'h01, 8'h01);
		repeat (28) @(negedge clk);
		chk(line_status_reg & 8'h21, 8'h20);
		done("freeze");
		apply(8'h40, 8'h00);
		repeat (90) @(negedge clk);
		overheat = 1'b1;
		repeat (8) @(negedge clk);
		chk(ci_up & 8'h10, 8'h10);
		overheat = 1'b0;
		gnd_fault = 1'b1;
		repeat (20) @(negedge clk);
		chk(ci_up & 8'h40, 8'h00);
		repeat (40) @(negedge clk);
		chk(ci_up & 8'h40, 8'h40);
		gnd_fault = 1'b0;
		done("thermal and ground key");
		apply(8'h00, 8'h00);
		repeat (90) @(negedge clk);
		offhook = 1'b1;
		repeat (10) @(negedge clk);
		chk(ci_up & 8'h80, 8'h00);
		repeat (40) @(negedge clk);
		chk(ci_up & 8'h80, 8'h80);
		offhook = 1'b0;
		done("denial hook");
		apply(8'hC0, 8'h00);
		repeat (90) @(negedge clk);
		chk({7'h00, ring_enable}, 8'h01);
		chk(ring_word, 8'h3C);
		chk(meter_word, 8'hC3);
		offhook = 1'b1;
		repeat (50) @(negedge clk);
		chk({7'h00, ring_enable}, 8'h00);
		chk(current_mode, slicmc_pkg::MODE_RING);
		done("ring trip");
		summarize();
	end
endmodule // slicmc_top_tb

bind slicmc_top slicmc_properties u_props (.clk, .rst, .active_feed_reg, .standby_feed_reg,
	.hv_control_line_a, .hv_control_line_b, .hv_power_enable_sink, .analog_power_on,
	.rx_oversample_tick, .metering_signal, .tip_hiz, .feed_word, .current_mode);
